// [rtl/sbcd_pkg.sv]
// Package of constants and types for the standby and clock divider control block
package sbcd_pkg;

  // Standby states
  typedef enum logic [1:0] {
    SBCD_RUN,
    SBCD_IDLE,
    SBCD_DEEP,
    SBCD_XTAL
  } sbcd_state_t;

  // Software request codes
  localparam logic [1:0] SBCD_REQ_NONE = 2'h0;
  localparam logic [1:0] SBCD_REQ_IDLE = 2'h1;
  localparam logic [1:0] SBCD_REQ_DEEP = 2'h2;
  localparam logic [1:0] SBCD_REQ_XTAL = 2'h3;

  // Clock source select codes
  localparam logic [1:0] SBCD_SRC_RC = 2'h0;
  localparam logic [1:0] SBCD_SRC_CF = 2'h1;
  localparam logic [1:0] SBCD_SRC_VRC = 2'h2;
  localparam logic [1:0] SBCD_SRC_XTAL = 2'h3;

  // Divider: nine settings, each doubling; base cycle is 3 main clocks
  localparam int SBCD_DIV_SETTINGS = 9;
  localparam logic [3:0] SBCD_DIV_MAX_SEL = 4'h8;
  localparam logic [1:0] SBCD_BASE_TICKS = 2'h3;
  localparam int SBCD_CNT_W = 10;
  localparam int SBCD_EXT_IRQS = 5;
  localparam int SBCD_SYNC_W = 3;

  // Oscillator enables
  typedef struct packed {
    logic ceramicOscillator;
    logic internalResistorCapOscillator;
    logic varRcOscillator;
    logic crystalOscillator;
  } sbcd_osc_t;

  // Wake sources, already synchronised
  typedef struct packed {
    logic [SBCD_EXT_IRQS-1:0] extIrq;
    logic port0Irq;
    logic baseTimerIrq;
    logic anyIrq;
  } sbcd_wake_t;

endpackage

// [rtl/sbcd_sync.sv]
// Three-stage synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sbcd_sync import sbcd_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sbcd_sync_st_t;

  sbcd_sync_st_t stFf;
  sbcd_sync_st_t nxtSt;

  // Accept a change only when stages two and three agree
  always_comb begin
    nxtSt = stFf;
    nxtSt.s1 = asyncIn;
    nxtSt.s2 = stFf.s1;
    nxtSt.s3 = stFf.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (stFf.s2[i] == stFf.s3[i]) begin
        nxtSt.q[i] = stFf.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stFf <= '0;
    end else begin
      stFf <= nxtSt;
    end
  end

  assign syncOut = stFf.q;

endmodule
`default_nettype wire

// [rtl/sbcd_ctrl.sv]
// Standby state controller and system clock divider
`timescale 1ns/100ps
`default_nettype none
module sbcd_ctrl import sbcd_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Software control, same clock
  input wire logic [1:0] standbyReq,
  input wire logic [3:0] divSel,
  input wire logic [1:0] clkSrcSel,
  input wire sbcd_osc_t oscRunReq,
  input wire logic anyIrqReq,
  // External pins, asynchronous
  input wire logic resetPin_b,
  input wire logic [SBCD_EXT_IRQS-1:0] extIrqActive,
  input wire logic port0IrqEst,
  input wire logic baseTimerIrqEst,
  // Outputs
  output logic coreClkGate,
  output logic periphClkGate,
  output logic baseTimerClkGate,
  output sbcd_osc_t oscEnable,
  output logic [1:0] sysClkSrc,
  output logic instrCycleTick,
  output sbcd_state_t standbyState
);

  typedef struct packed {
    sbcd_state_t st;
    sbcd_osc_t osc;
    logic xtalHeld;
    logic coreGate;
    logic periphGate;
    logic btGate;
    logic [1:0] src;
    logic [SBCD_CNT_W-1:0] cnt;
    logic tick;
  } sbcd_ctrl_st_t;

  sbcd_ctrl_st_t stFf;
  sbcd_ctrl_st_t nxtSt;
  logic [SBCD_EXT_IRQS+2:0] pinsSync;
  logic pinResetSync_b;
  logic extWake;

  // Pins cross through four flip-flops: three stages, then the filtered output
  sbcd_sync #(.WIDTH(SBCD_EXT_IRQS + 3)) uSync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .asyncIn({~resetPin_b, extIrqActive, port0IrqEst, baseTimerIrqEst}),
    .syncOut(pinsSync)
  );

  assign pinResetSync_b = ~pinsSync[SBCD_EXT_IRQS+2];

  // Stop-state wake: pin reset, irq pins, port 0
  assign extWake = (!pinResetSync_b)
                 | (|pinsSync[SBCD_EXT_IRQS+1:2])
                 | pinsSync[1];

  // Terminal count of the divider, base ticks doubled per setting
  function automatic logic [SBCD_CNT_W-1:0] divLimit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > SBCD_DIV_MAX_SEL) ? SBCD_DIV_MAX_SEL : sel;
    divLimit = SBCD_CNT_W'((SBCD_CNT_W'(SBCD_BASE_TICKS) << s) - 1'b1);
  endfunction

  // Next state
  always_comb begin
    nxtSt = stFf;
    nxtSt.tick = 1'b0;
    nxtSt.src = clkSrcSel;
    case (stFf.st)
      SBCD_RUN: begin
        nxtSt.osc = oscRunReq;
        nxtSt.coreGate = 1'b1;
        nxtSt.periphGate = 1'b1;
        nxtSt.btGate = 1'b1;
        case (standbyReq)
          SBCD_REQ_IDLE: begin
            nxtSt.st = SBCD_IDLE;
            nxtSt.coreGate = 1'b0;
            // Keep what ran before entry, not a request changed in this cycle
            nxtSt.osc = stFf.osc;
          end
          SBCD_REQ_DEEP: begin
            nxtSt.st = SBCD_DEEP;
            nxtSt.coreGate = 1'b0;
            nxtSt.periphGate = 1'b0;
            nxtSt.btGate = 1'b0;
            nxtSt.osc = '0;
          end
          SBCD_REQ_XTAL: begin
            nxtSt.st = SBCD_XTAL;
            nxtSt.coreGate = 1'b0;
            nxtSt.periphGate = 1'b0;
            nxtSt.osc.ceramicOscillator = 1'b0;
            nxtSt.osc.internalResistorCapOscillator = 1'b0;
            nxtSt.osc.varRcOscillator = 1'b0;
            nxtSt.osc.crystalOscillator = stFf.osc.crystalOscillator;
            nxtSt.xtalHeld = stFf.osc.crystalOscillator;
          end
          default: begin
            nxtSt.st = SBCD_RUN;
          end
        endcase
      end
      SBCD_IDLE: begin
        // Oscillators keep their pre-entry state
        nxtSt.osc = stFf.osc;
        if (anyIrqReq || !pinResetSync_b) begin
          nxtSt.st = SBCD_RUN;
          nxtSt.coreGate = 1'b1;
        end
      end
      SBCD_DEEP: begin
        nxtSt.osc = '0;
        if (extWake) begin
          nxtSt.st = SBCD_RUN;
          nxtSt.coreGate = 1'b1;
          nxtSt.periphGate = 1'b1;
          nxtSt.btGate = 1'b1;
        end
      end
      SBCD_XTAL: begin
        nxtSt.osc.crystalOscillator = stFf.xtalHeld;
        if (extWake || pinsSync[0]) begin
          nxtSt.st = SBCD_RUN;
          nxtSt.coreGate = 1'b1;
          nxtSt.periphGate = 1'b1;
        end
      end
      default: begin
        nxtSt.st = SBCD_RUN;
      end
    endcase
    // Divider runs only while the core clock runs; saves power in standby
    if (stFf.coreGate) begin
      if (stFf.cnt >= divLimit(divSel)) begin
        nxtSt.cnt = '0;
        nxtSt.tick = 1'b1;
      end else begin
        nxtSt.cnt = stFf.cnt + 1'b1;
      end
    end else begin
      nxtSt.cnt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stFf.st <= SBCD_RUN;
      stFf.osc <= '1;
      stFf.xtalHeld <= 1'b0;
      stFf.coreGate <= 1'b1;
      stFf.periphGate <= 1'b1;
      stFf.btGate <= 1'b1;
      stFf.src <= SBCD_SRC_RC;
      stFf.cnt <= '0;
      stFf.tick <= 1'b0;
    end else begin
      stFf <= nxtSt;
    end
  end

  // Outputs straight from flip-flops
  assign coreClkGate = stFf.coreGate;
  assign periphClkGate = stFf.periphGate;
  assign baseTimerClkGate = stFf.btGate;
  assign oscEnable = stFf.osc;
  assign sysClkSrc = stFf.src;
  assign instrCycleTick = stFf.tick;
  assign standbyState = stFf.st;

  sequence s_enterDeep;
    stFf.st == SBCD_RUN && standbyReq == SBCD_REQ_DEEP;
  endsequence

  sequence s_enterXtal;
    stFf.st == SBCD_RUN && standbyReq == SBCD_REQ_XTAL;
  endsequence

  AST_DEEP_OSC_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_enterDeep |=> oscEnable == '0 && !periphClkGate)
    else $error("deep stop left an oscillator on");
  AST_XTAL_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_enterXtal |=> oscEnable.crystalOscillator == $past(oscEnable.crystalOscillator))
    else $error("crystal state changed on keepalive entry");
  AST_XTAL_RC_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_enterXtal |=> !oscEnable.ceramicOscillator && !oscEnable.internalResistorCapOscillator
      && baseTimerClkGate)
    else $error("keepalive entry left fast oscillators on");
  AST_IDLE_OSC: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_RUN && standbyReq == SBCD_REQ_IDLE |=> oscEnable == $past(oscEnable)
      && periphClkGate)
    else $error("idle entry altered oscillators");
  AST_GATE_NEXT: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_RUN && standbyReq != SBCD_REQ_NONE |=> !coreClkGate)
    else $error("core clock not gated after request");
  AST_IDLE_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_IDLE && anyIrqReq |=> coreClkGate && standbyState == SBCD_RUN)
    else $error("idle not released by interrupt");
  AST_DEEP_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_DEEP && extWake |=> coreClkGate && periphClkGate
      && standbyState == SBCD_RUN)
    else $error("deep stop not released by wake");
  AST_XTAL_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_XTAL && extWake |=> standbyState == SBCD_RUN && periphClkGate)
    else $error("keepalive not released by pin wake");
  AST_DEEP_NO_BT: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_DEEP && !extWake |=> standbyState == SBCD_DEEP)
    else $error("deep stop released without cause");
  AST_XTAL_BT: assert property (@(posedge core_clk) disable iff (!rst_b)
    stFf.st == SBCD_XTAL && pinsSync[0] |=> standbyState == SBCD_RUN)
    else $error("keepalive not released by base timer");
  AST_TICK_GAP: assert property (@(posedge core_clk) disable iff (!rst_b)
    instrCycleTick && divSel == '0 && $stable(divSel) && coreClkGate ##1 coreClkGate
      |-> !instrCycleTick ##1 !instrCycleTick)
    else $error("base divider tick too frequent");

endmodule
`default_nettype wire

// [sim/sbcd_wake_model.sv]
// Wake-pin side model: irq lines, port 0, base timer and reset pin
`timescale 1ns/100ps
`default_nettype none
module sbcd_wake_model import sbcd_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Bench commands: bits 0..4 irq lines, 5 port 0, 6 base timer, 7 reset pin
  input wire logic [7:0] fire,
  input wire logic [3:0] lag,
  // Pins towards the block
  output logic resetPin_b,
  output logic [SBCD_EXT_IRQS-1:0] extIrqActive,
  output logic port0IrqEst,
  output logic baseTimerIrqEst
);
  logic [7:0] pinsFf;
  logic [3:0] waitFf;

  // Quiet pins from time zero
  initial begin
    pinsFf = 8'h00;
    waitFf = 4'h0;
  end

  // Lines assert after lag edges, so both prompt and slow sources occur
  always @(posedge core_clk) begin
    if (fire == 8'h00) begin
      waitFf <= 4'h0;
      pinsFf <= 8'h00;
    end else if (waitFf >= lag) begin
      pinsFf <= fire;
    end else begin
      waitFf <= waitFf + 4'h1;
    end
  end

  // Released lines fall to inactive; reset pin is pulled high
  assign extIrqActive = pinsFf[4:0];
  assign port0IrqEst = pinsFf[5];
  assign baseTimerIrqEst = pinsFf[6];
  assign resetPin_b = ~pinsFf[7];
endmodule
`default_nettype wire

// [sim/standby_clock_divider_control_tb.sv]
// Self-checking bench for the standby and clock divider control
`timescale 1ns/100ps
`default_nettype none
module standby_clock_divider_control_tb;
  import sbcd_pkg::*;
  logic core_clk, rst_b, anyIrqReq, coreClkGate, periphClkGate, baseTimerClkGate;
  logic resetPin_b, port0IrqEst, baseTimerIrqEst, instrCycleTick;
  logic [1:0] standbyReq, clkSrcSel, sysClkSrc;
  logic [3:0] divSel, lag;
  logic [7:0] fire;
  logic [SBCD_EXT_IRQS-1:0] extIrqActive;
  sbcd_osc_t oscRunReq, oscEnable;
  sbcd_state_t standbyState;
  int miscompares = 0;
  int checks_done = 0;

  // Device under test and wake-pin model
  sbcd_ctrl i_sbcd_ctrl (.core_clk(core_clk), .rst_b(rst_b), .standbyReq(standbyReq),
    .divSel(divSel), .clkSrcSel(clkSrcSel), .oscRunReq(oscRunReq), .anyIrqReq(anyIrqReq),
    .resetPin_b(resetPin_b), .extIrqActive(extIrqActive), .port0IrqEst(port0IrqEst),
    .baseTimerIrqEst(baseTimerIrqEst), .coreClkGate(coreClkGate),
    .periphClkGate(periphClkGate), .baseTimerClkGate(baseTimerClkGate),
    .oscEnable(oscEnable), .sysClkSrc(sysClkSrc), .instrCycleTick(instrCycleTick),
    .standbyState(standbyState));
  sbcd_wake_model i_sbcd_wake_model (.core_clk(core_clk), .fire(fire), .lag(lag),
    .resetPin_b(resetPin_b), .extIrqActive(extIrqActive), .port0IrqEst(port0IrqEst),
    .baseTimerIrqEst(baseTimerIrqEst));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs move 1 ns after the rising edge
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  // Bounded wait for a state; running out ends the run
  task automatic waitSt(input sbcd_state_t s);
    int n;
    n = 0;
    while (standbyState !== s && n < 24) begin
      step();
      n++;
    end
    if (standbyState !== s) begin
      miscompares++;
      $display("ERROR t=%0t state=%h exp=%h", $time, standbyState, s);
      wrap_up();
    end
  endtask

  task automatic enter(input logic [1:0] req, input sbcd_state_t s);
    standbyReq = req;
    step();
    standbyReq = 2'h0;
    waitSt(s);
    chk(16'(coreClkGate), 16'h0000);
  endtask

  // Idle keeps peripherals and oscillators, any interrupt ends it
  task automatic idleCase;
    oscRunReq = 4'ha;
    step();
    enter(SBCD_REQ_IDLE, SBCD_IDLE);
    chk(16'(periphClkGate), 16'h0001);
    chk(16'(oscEnable), 16'h000a);
    anyIrqReq = 1'b1;
    waitSt(SBCD_RUN);
    anyIrqReq = 1'b0;
    chk(16'(coreClkGate), 16'h0001);
  endtask

  // Deep stop with every pin wake source, base timer must not wake
  task automatic deepCase;
    for (int i = 0; i < 7; i++) begin
      oscRunReq = 4'hf;
      enter(SBCD_REQ_DEEP, SBCD_DEEP);
      chk(16'({periphClkGate, baseTimerClkGate}), 16'h0000);
      chk(16'({oscEnable.ceramicOscillator, oscEnable.internalResistorCapOscillator,
               oscEnable.crystalOscillator}), 16'h0000);
      lag = 4'h0;
      fire = 8'h40;
      anyIrqReq = 1'b1;
      repeat (10) step();
      chk(16'(standbyState), 16'(SBCD_DEEP));
      anyIrqReq = 1'b0;
      fire = 8'h00;
      repeat (6) step();
      lag = i[3:0];
      fire = (i == 6) ? 8'h80 : 8'h01 << i;
      waitSt(SBCD_RUN);
      fire = 8'h00;
      repeat (6) step();
      chk(16'(oscEnable), 16'h000f);
    end
  endtask

  // Crystal keepalive with crystal off and on, woken by base timer
  task automatic xtalCase;
    for (int c = 0; c < 2; c++) begin
      oscRunReq = {3'b101, c[0]};
      step();
      enter(SBCD_REQ_XTAL, SBCD_XTAL);
      chk(16'({periphClkGate, baseTimerClkGate}), 16'h0001);
      chk(16'({oscEnable.ceramicOscillator, oscEnable.internalResistorCapOscillator}),
          16'h0000);
      repeat (5) step();
      chk(16'(oscEnable.crystalOscillator), 16'(c[0]));
      lag = 4'h3;
      fire = 8'h40;
      waitSt(SBCD_RUN);
      fire = 8'h00;
      repeat (6) step();
    end
  endtask

  // Bounded wait for the next tick; n counts steps after the first
  task automatic waitTick(output int n);
    n = 0;
    step();
    while (instrCycleTick !== 1'b1 && n < 800) begin
      step();
      n++;
    end
    if (instrCycleTick !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t tick=%h exp=%h", $time, instrCycleTick, 1'b1);
      wrap_up();
    end
  endtask

  // Every divider setting and clock source, then an out-of-range setting
  task automatic divCase;
    int n;
    for (int s = 0; s < 9; s++) begin
      divSel = s[3:0];
      clkSrcSel = s[1:0];
      waitTick(n);
      waitTick(n);
      waitTick(n);
      chk(16'(n + 1), 16'(3 << s));
      chk(16'(sysClkSrc), 16'(s[1:0]));
    end
    // Settings above the last clamp to it
    divSel = 4'hf;
    waitTick(n);
    waitTick(n);
    chk(16'(n + 1), 16'(3 << SBCD_DIV_MAX_SEL));
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    standbyReq = 2'h0;
    divSel = 4'h0;
    clkSrcSel = 2'h0;
    oscRunReq = 4'hf;
    anyIrqReq = 1'b0;
    fire = 8'h00;
    lag = 4'h0;
    repeat (4) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk(16'({standbyState, coreClkGate, periphClkGate, oscEnable}), 16'h003f);
    repeat (4) step();
    idleCase();
    deepCase();
    xtalCase();
    divCase();
    wrap_up();
  end
endmodule
`default_nettype wire
